// File: verilog/ucsma_seq.v
// unslotted channel-access transmit sequencer with signal-strength averaging
`default_nettype none
`include "ucsma_defines.vh"

module ucsma_seq #(
    parameter integer BACKOFF_CYC = `UCSMA_BACKOFF_NS / `UCSMA_CLK_NS,
    parameter integer CCA_CYC     = `UCSMA_CCA_NS / `UCSMA_CLK_NS,
    parameter integer TURN_CYC    = (`UCSMA_TURN_NS + `UCSMA_CLK_NS - 1) / `UCSMA_CLK_NS,
    parameter integer ACK_CYC     = `UCSMA_ACK_WAIT_NS / `UCSMA_CLK_NS,
    parameter integer US_CYC      = `UCSMA_US_NS / `UCSMA_CLK_NS,
    parameter integer BUF_AW      = 8
) (
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // register port
    input  wire [11:0] addr,
    input  wire [7:0]  wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [7:0]  rdata,
    // radio front end
    input  wire signed [7:0] rssi_sample,
    input  wire        rssi_valid,
    input  wire        sfd_det,
    input  wire        ack_rcvd,
    output reg         tx_start,
    input  wire        tx_done,
    output wire        rx_on,
    output wire        tx_on,
    // frame rssi write into receive buffer
    output reg         fcs_rssi_we,
    output reg  [7:0]  fcs_rssi,
    // completion and status
    output reg         access_done_irq,
    output reg         access_fail,
    output wire        idle_ready_state
);
    // ----------------------------------------------------------------
    // states, one-hot
    // ----------------------------------------------------------------
    localparam [7:0] S_IDLE = 8'h01;
    localparam [7:0] S_DLY  = 8'h02;
    localparam [7:0] S_BOFF = 8'h04;
    localparam [7:0] S_CCA  = 8'h08;
    localparam [7:0] S_TURN = 8'h10;
    localparam [7:0] S_TX   = 8'h20;
    localparam [7:0] S_ACK  = 8'h40;
    localparam [7:0] S_END  = 8'h80;

    reg  [7:0]  st_q;                 // sequencer state
    reg  [7:0]  buf_q [0:(1<<BUF_AW)-1]; // transmit buffer image
    reg  [7:0]  cfg_q;                // retry, enable, force-ack bits
    reg  [7:0]  thres_q;              // clear-channel threshold, signed dBm
    reg  [7:0]  gain5_q;              // holds rssi offset field
    reg  [7:0]  base_q;               // transmit frame pointer
    reg  [7:0]  mdelay_q;             // mac delay in microseconds
    reg  [7:0]  rssi_rb_q;            // readback value
    reg  [31:0] tmr_q;                // shared phase timer
    reg  [15:0] lfsr_q;               // backoff random source
    reg  [2:0]  cca_cnt_q;            // cca retries used
    reg  [2:0]  frm_cnt_q;            // frame retries used
    reg  [2:0]  be_q;                 // backoff exponent
    reg         ack_req_q;            // ack expected for this frame
    reg  [3:0]  avg_n_q;              // samples in window
    reg  signed [11:0] avg_acc_q;     // window accumulator
    reg  [15:0] win_q;                // window length counter
    reg         fr_meas_q;            // frame rssi window active
    reg  [15:0] us_q;                 // microsecond prescaler
    reg  [7:0]  dly_q;                // mac delay counter
    reg         rx_act_q;             // active reception after mac delay

    // derived controls from the config registers
    // the cca retry field above five is clamped, never wrapped; the frame retry field is used as written
    wire [2:0] cca_max = (cfg_q[`UCSMA_CFG_RETRY_MSB:`UCSMA_CFG_RETRY_LSB] > `UCSMA_MAX_CCA_RETRY) ?
                         `UCSMA_MAX_CCA_RETRY : cfg_q[`UCSMA_CFG_RETRY_MSB:`UCSMA_CFG_RETRY_LSB];
    wire [2:0] frm_max = cfg_q[`UCSMA_CFG_FRETRY_MSB:`UCSMA_CFG_FRETRY_LSB];
    wire       csma_en = cfg_q[`UCSMA_CFG_CSMA_EN];
    wire       force_ack_wait = cfg_q[`UCSMA_CFG_FORCE_ACK];
    wire [2:0] offs = gain5_q[`UCSMA_OFFS_MSB:`UCSMA_OFFS_LSB];
    wire       start = wr && (addr == `UCSMA_ADDR_CMD) && (wdata == `UCSMA_CMD_START) && st_q[0];
    wire       receiving = st_q[2] | st_q[3] | st_q[6] | st_q[1];

    assign rx_on = receiving;
    assign tx_on = st_q[5] | st_q[4];
    assign idle_ready_state = st_q[0];

    // random draw masked to 2^be-1: uniform because the mask is all ones
    wire [7:0] bo_mask = (8'h01 << be_q) - 8'h01;
    wire [7:0] bo_draw = lfsr_q[7:0] & bo_mask;

    // running window sum; the divide by eight is a plain shift
    wire signed [11:0] avg_sum = avg_acc_q + {{4{rssi_sample[7]}}, rssi_sample};
    // finished window average plus offset, read as the check ends;
    // the live sample is left out so exactly eight samples count
    wire signed [7:0]  avg_val = avg_acc_q[10:3] + {5'h00, offs};

    // backoff over: the check opens a fresh averaging window, else
    // it could end just after a window restart and judge the
    // channel on one or two samples
    wire       cca_go = st_q[2] && (tmr_q == 32'h0);

    // ----------------------------------------------------------------
    // register writes and buffer
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            cfg_q    <= `UCSMA_RST_CFG;
            thres_q  <= `UCSMA_RST_THRES;
            gain5_q  <= 8'h00;
            base_q   <= 8'h00;
            mdelay_q <= `UCSMA_RST_DELAY;
        end else if (wr) begin
            // command address has no storage, it only decodes start
            case (addr)
                `UCSMA_ADDR_CSMA_CFG:  cfg_q    <= wdata;
                `UCSMA_ADDR_CCA_THRES: thres_q  <= wdata;
                `UCSMA_ADDR_GAIN_CFG5: gain5_q  <= wdata;
                `UCSMA_ADDR_TX_BASE:   base_q   <= wdata;
                `UCSMA_ADDR_MAC_DELAY: mdelay_q <= wdata;
                default: ;
            endcase
        end
    end

    // buffer window sits at the bottom page of the map; no reset on storage
    always @(posedge clk) begin
        if (wr && addr[11:BUF_AW] == `UCSMA_BUF_SEL)
            buf_q[addr[BUF_AW-1:0]] <= wdata;
    end

    // ----------------------------------------------------------------
    // read port, data the cycle after the strobe
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (rd) begin
            if (addr[11:BUF_AW] == `UCSMA_BUF_SEL)
                rdata <= buf_q[addr[BUF_AW-1:0]];
            else begin
                // readback, config and status registers
                case (addr)
                    `UCSMA_ADDR_RSSI_RB:   rdata <= rssi_rb_q;
                    `UCSMA_ADDR_GAIN_CFG5: rdata <= gain5_q;
                    `UCSMA_ADDR_CCA_THRES: rdata <= thres_q;
                    `UCSMA_ADDR_TX_BASE:   rdata <= base_q;
                    `UCSMA_ADDR_CSMA_CFG:  rdata <= cfg_q;
                    `UCSMA_ADDR_MAC_DELAY: rdata <= mdelay_q;
                    `UCSMA_ADDR_STATUS:    rdata <= {access_fail, 1'b0, frm_cnt_q, cca_cnt_q};
                    default:               rdata <= 8'h00; // unmapped reads as zero
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // microsecond tick and mac delay before active reception
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            us_q     <= 16'h0000;
            dly_q    <= 8'h00;
            rx_act_q <= 1'b0;
        end else if (!receiving) begin
            // receiver off: the delay restarts at the next receive
            us_q     <= 16'h0000;
            dly_q    <= 8'h00;
            rx_act_q <= 1'b0;
        end else if (!rx_act_q) begin
            // window only opens once mac delay has run out
            if (us_q == US_CYC[15:0] - 16'h0001) begin
                us_q  <= 16'h0000;
                dly_q <= dly_q + 8'h01;
                if (dly_q + 8'h01 >= mdelay_q)
                    rx_act_q <= 1'b1;
            end else begin
                us_q <= us_q + 16'h0001;
            end
            if (mdelay_q == 8'h00)
                rx_act_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // signal-strength averaging, 8 samples over 128 us
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            avg_n_q     <= 4'h0;
            avg_acc_q   <= 12'h000;
            win_q       <= 16'h0000;
            rssi_rb_q   <= 8'h00;
            fr_meas_q   <= 1'b0;
            fcs_rssi_we <= 1'b0;
            fcs_rssi    <= 8'h00;
        end else begin
            fcs_rssi_we <= 1'b0;
            if (sfd_det && rx_act_q) begin
                // restart window on delimiter for frame rssi
                fr_meas_q <= 1'b1;
                avg_n_q   <= 4'h0;
                avg_acc_q <= 12'h000;
                win_q     <= 16'h0000;
            end else if (!rx_act_q) begin
                // nothing is averaged before active reception
                avg_n_q   <= 4'h0;
                avg_acc_q <= 12'h000;
                win_q     <= 16'h0000;
                fr_meas_q <= 1'b0;
            end else if (cca_go) begin
                // window aligned with the
                avg_n_q   <= 4'h0;
                avg_acc_q <= 12'h000;
                win_q     <= 16'h0000;
            end else begin
                win_q <= win_q + 16'h0001;
                if (rssi_valid && avg_n_q != 4'h8) begin
                    avg_n_q   <= avg_n_q + 4'h1;
                    avg_acc_q <= avg_sum;
                end
                // window closes after 128 us, eight symbol periods
                if (win_q == CCA_CYC[15:0] - 16'h0001) begin
                    rssi_rb_q <= avg_acc_q[10:3] + {5'h00, offs};
                    if (fr_meas_q) begin
                        fcs_rssi_we <= 1'b1;
                        fcs_rssi    <= avg_acc_q[10:3] + {5'h00, offs};
                        fr_meas_q   <= 1'b0;
                    end
                    win_q     <= 16'h0000;
                    avg_n_q   <= 4'h0;
                    avg_acc_q <= 12'h000;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            st_q            <= S_IDLE;
            tmr_q           <= 32'h0;
            lfsr_q          <= `UCSMA_RST_LFSR;
            cca_cnt_q       <= 3'h0;
            frm_cnt_q       <= 3'h0;
            be_q            <= 3'h0;
            ack_req_q       <= 1'b0;
            tx_start        <= 1'b0;
            access_done_irq <= 1'b0;
            access_fail     <= 1'b0;
        end else begin
            // free-running source so the draw differs each attempt
            lfsr_q          <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
            tx_start        <= 1'b0;
            access_done_irq <= 1'b0;
            case (st_q)
                // wait for the start command
                S_IDLE: begin
                    if (start) begin
                        // fresh counters; ack request sampled once here
                        cca_cnt_q   <= 3'h0;
                        frm_cnt_q   <= 3'h0;
                        be_q        <= `UCSMA_MIN_BE;
                        access_fail <= 1'b0;
                        ack_req_q   <= buf_q[base_q + 8'h01][`UCSMA_ACK_REQ_BIT];
                        st_q        <= S_DLY;
                    end
                end
                S_DLY: begin
                    // wait for mac delay; disabled access skips backoff and cca
                    if (rx_act_q) begin
                        tmr_q <= 32'h0;
                        if (!csma_en)
                            st_q <= S_TX;
                        else begin
                            tmr_q <= bo_draw * BACKOFF_CYC;
                            st_q  <= S_BOFF;
                        end
                        tx_start <= !csma_en;
                    end
                end
                // count down the drawn backoff periods
                S_BOFF: begin
                    if (tmr_q == 32'h0) begin
                        tmr_q <= CCA_CYC - 1;
                        st_q  <= S_CCA;
                    end else
                        tmr_q <= tmr_q - 32'h1;
                end
                // observe for the full window, then judge
                S_CCA: begin
                    if (tmr_q != 32'h0)
                        tmr_q <= tmr_q - 32'h1; // observe full window
                    else if (avg_val < $signed(thres_q)) begin
                        tmr_q <= TURN_CYC - 1;
                        st_q  <= S_TURN;
                    end else if (cca_cnt_q < cca_max) begin
                        cca_cnt_q <= cca_cnt_q + 3'h1;
                        // exponent grows per busy check, capped at five
                        if (be_q != 3'h5)
                            be_q <= be_q + 3'h1;
                        tmr_q <= bo_draw * BACKOFF_CYC;
                        st_q  <= S_BOFF;
                    end else begin
                        access_fail <= 1'b1;
                        st_q        <= S_END;
                    end
                end
                // receive-to-transmit turnaround
                S_TURN: begin
                    if (tmr_q == 32'h0) begin
                        tx_start <= 1'b1;
                        st_q     <= S_TX;
                    end else
                        tmr_q <= tmr_q - 32'h1;
                end
                // frame on air until the radio reports done
                S_TX: begin
                    if (tx_done) begin
                        if (ack_req_q || force_ack_wait) begin
                            tmr_q <= ACK_CYC - 1;
                            st_q  <= S_ACK;
                        end else
                            st_q <= S_END;
                    end
                end
                // listen for the ack until the timer runs out
                S_ACK: begin
                    if (ack_rcvd)
                        st_q <= S_END;
                    else if (tmr_q != 32'h0)
                        tmr_q <= tmr_q - 32'h1;
                    else if (frm_cnt_q < frm_max) begin
                        // frame retry goes back through the mac delay
                        frm_cnt_q <= frm_cnt_q + 3'h1;
                        cca_cnt_q <= 3'h0;
                        be_q      <= `UCSMA_MIN_BE;
                        st_q      <= S_DLY;
                    end else begin
                        access_fail <= 1'b1;
                        st_q        <= S_END;
                    end
                end
                // one-cycle completion pulse, whatever the outcome
                S_END: begin
                    access_done_irq <= 1'b1;
                    st_q            <= S_IDLE;
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: verilog/ucsma_defines.vh
// constants for the unslotted channel-access sequencer
`ifndef UCSMA_DEFINES_VH
`define UCSMA_DEFINES_VH
// ----------------------------------------------------------------
// register map (printed offsets, byte addresses on a 12-bit port)
// ----------------------------------------------------------------
`define UCSMA_ADDR_RSSI_RB     12'h30C
`define UCSMA_ADDR_GAIN_CFG5   12'h3B9
`define UCSMA_ADDR_CCA_THRES   12'h105
`define UCSMA_ADDR_TX_BASE     12'h314
`define UCSMA_ADDR_CSMA_CFG    12'h3C0
`define UCSMA_ADDR_CMD         12'h3C1
`define UCSMA_ADDR_STATUS      12'h3C2
`define UCSMA_ADDR_MAC_DELAY   12'h3C3
`define UCSMA_ADDR_BUF_BASE    12'h000
`define UCSMA_BUF_SEL_BITS     4
`define UCSMA_BUF_SEL          4'h0
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define UCSMA_OFFS_LSB         2
`define UCSMA_OFFS_MSB         4
`define UCSMA_CFG_RETRY_LSB    0
`define UCSMA_CFG_RETRY_MSB    2
`define UCSMA_CFG_FRETRY_LSB   3
`define UCSMA_CFG_FRETRY_MSB   5
`define UCSMA_CFG_CSMA_EN      6
`define UCSMA_CFG_FORCE_ACK    7
`define UCSMA_ACK_REQ_BIT      5
`define UCSMA_CMD_START        8'h01
`define UCSMA_MAX_CCA_RETRY    3'h5
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define UCSMA_RST_CFG          8'h43
`define UCSMA_RST_THRES        8'hAD
`define UCSMA_RST_DELAY        8'hC0
`define UCSMA_RST_LFSR         16'hACE1
// ----------------------------------------------------------------
// timing: times in ns, clock period 4 ns
// ----------------------------------------------------------------
`define UCSMA_CLK_NS           4
`define UCSMA_BACKOFF_NS       320000
`define UCSMA_CCA_NS           128000
`define UCSMA_TURN_NS          106000
`define UCSMA_ACK_WAIT_NS      864000
`define UCSMA_US_NS            1000
`define UCSMA_MIN_BE           3
`endif

// File: tb/ucsma_radio_model.sv
// radio front-end model: signal-strength source, frame air time, ack reply
`default_nettype none
module ucsma_radio_model (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // from the sequencer
    input  wire logic              tx_start,
    input  wire logic              rx_on,
    // scenario controls
    input  wire logic signed [7:0] level,
    input  wire logic              ack_en,
    input  wire logic [7:0]        tx_len,
    // to the sequencer
    output logic signed [7:0]      rssi_sample,
    output logic                   rssi_valid,
    output logic                   tx_done,
    output logic                   sfd_det,
    output logic                   ack_rcvd
);
    timeunit 1ns;
    timeprecision 1ps;
    int tx_q;  // air cycles left of the frame being sent
    int ak_q;  // cycles until the ack frame lands, 0 when none pending
    // one clocked process; tx_len picks a prompt or a slow frame
    always @(posedge clk) begin
        if (!rst_n) begin
            tx_q <= 0;
            ak_q <= 0;
            rssi_sample <= 8'sh00;
        end else begin
            tx_q <= tx_start ? int'(tx_len) : (tx_q > 0 ? tx_q - 1 : 0);
            ak_q <= (tx_q == 1 && ack_en) ? 6 : (ak_q > 0 ? ak_q - 1 : 0);
            // off air the sample line carries no steady value
            rssi_sample <= rx_on ? level : ~rssi_sample;
        end
        rssi_valid <= rst_n && rx_on;
        tx_done <= rst_n && tx_q == 1;
        // ack frame: delimiter first, then the frame, only if listening
        sfd_det <= rst_n && ak_q == 4 && rx_on;
        ack_rcvd <= rst_n && ak_q == 1 && rx_on;
    end
endmodule
`default_nettype wire

// File: tb/ucsma_seq_sva.sv
// port assertions for the channel-access sequencer
`default_nettype none
`include "ucsma_defines.vh"
module ucsma_seq_sva #(
    parameter integer TURN_CYC = 10
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // register port
    input wire logic [11:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [7:0]  rdata,
    // sequencer outputs
    input wire logic        tx_start,
    input wire logic        rx_on,
    input wire logic        tx_on,
    input wire logic        access_done_irq,
    input wire logic        idle_ready_state
);
    logic en_q;  // access check enable, snooped from config writes
    int   run_q; // consecutive cycles with the transmit path up
    // helper state; turnaround only counts from the rise of tx_on
    always @(posedge clk) begin
        if (!rst_n) begin
            en_q <= 1'b1;
            run_q <= 0;
        end else begin
            if (wr && addr == `UCSMA_ADDR_CSMA_CFG) en_q <= wdata[`UCSMA_CFG_CSMA_EN];
            run_q <= tx_on ? run_q + 1 : 0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_start_rx_on: assert property (wr && addr == `UCSMA_ADDR_CMD && wdata == `UCSMA_CMD_START
        && idle_ready_state |=> rx_on) else $error("start did not enable receive");
    a_irq_single: assert property (access_done_irq |=> !access_done_irq)
        else $error("done pulse too long");
    a_irq_then_idle: assert property (access_done_irq |-> ##[0:1] idle_ready_state)
        else $error("no idle after done");
    a_idle_via_irq: assert property ($rose(idle_ready_state) |-> access_done_irq || $past(access_done_irq))
        else $error("idle reached without done pulse");
    a_turn_min: assert property (tx_start && en_q |-> run_q >= TURN_CYC - 1)
        else $error("turnaround too short");
    a_idle_no_tx: assert property (idle_ready_state |-> !tx_on && !tx_start)
        else $error("transmit while idle");
    a_tx_pulse: assert property (tx_start |=> !tx_start)
        else $error("frame start not a pulse");
    a_rdata_hold: assert property (!rd |=> $stable(rdata))
        else $error("read data moved without read");
    a_unmapped_zero: assert property (rd && addr == 12'h7FF |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    c_done: cover property (access_done_irq);
    c_direct_tx: cover property (tx_start && !en_q);
    c_ack_listen: cover property ($fell(tx_on) && rx_on);
endmodule
bind ucsma_seq ucsma_seq_sva #(.TURN_CYC(TURN_CYC)) ucsma_seq_sva_i (.clk(clk), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tx_start(tx_start), .rx_on(rx_on),
    .tx_on(tx_on), .access_done_irq(access_done_irq), .idle_ready_state(idle_ready_state));
`default_nettype wire

// File: tb/ucsma_seq_test.sv
// self-checking bench for the channel-access sequencer
`default_nettype none
`include "ucsma_defines.vh"
module ucsma_seq_test;
    timeunit 1ns;
    timeprecision 1ps;
    // shortened counts keep the run brief
    localparam int BO = 40, CCA = 40, TURN = 10, ACK = 40, US = 2;
    logic clk, rst_n, wr, rd, ack_en;
    logic [11:0] addr;
    logic [7:0]  wdata, rdata, tx_len, fcs_rssi, d0, d1;
    logic signed [7:0] level, rssi_sample;
    logic rssi_valid, sfd_det, ack_rcvd, tx_start, tx_done, rx_on, tx_on;
    logic fcs_rssi_we, access_done_irq, access_fail, idle_ready_state;
    int err_count, check_count, n_tx, t_tx, t_last, t0, now_c, cyc;
    ucsma_seq #(.BACKOFF_CYC(BO), .CCA_CYC(CCA), .TURN_CYC(TURN), .ACK_CYC(ACK), .US_CYC(US)) ucsma_seq_i (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .rssi_sample(rssi_sample), .rssi_valid(rssi_valid), .sfd_det(sfd_det), .ack_rcvd(ack_rcvd),
        .tx_start(tx_start), .tx_done(tx_done), .rx_on(rx_on), .tx_on(tx_on), .fcs_rssi_we(fcs_rssi_we),
        .fcs_rssi(fcs_rssi), .access_done_irq(access_done_irq), .access_fail(access_fail),
        .idle_ready_state(idle_ready_state));
    ucsma_radio_model ucsma_radio_model_i (.clk(clk), .rst_n(rst_n), .tx_start(tx_start), .rx_on(rx_on),
        .level(level), .ack_en(ack_en), .tx_len(tx_len), .rssi_sample(rssi_sample), .rssi_valid(rssi_valid),
        .tx_done(tx_done), .sfd_det(sfd_det), .ack_rcvd(ack_rcvd));
    // ------------------------------------------------------------
    // clock, frame-start watcher, closing report
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // tx_start is a registered pulse: sample it once it has settled
    always @(posedge clk) begin
        #1;
        now_c++;
        if (tx_start === 1'b1) begin
            if (n_tx == 0) t_tx = now_c;
            t_last = now_c;
            n_tx++;
        end
    end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // register port tasks and compares
    // ------------------------------------------------------------
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand from the cycle after the strobe until the next read
    task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // launch one procedure and wait, bounded, for its done pulse
    task automatic run_proc();
        n_tx = 0;
        wr_reg(`UCSMA_ADDR_CMD, `UCSMA_CMD_START);
        t0 = now_c;
        cyc = 0;
        do begin
            @(posedge clk);
            #1;
            cyc++;
        end while (access_done_irq !== 1'b1 && cyc < 20000);
        if (cyc >= 20000) begin
            err_count++;
            report_and_stop();
        end
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 12'h000;
        wdata = 8'h00;
        level = 8'sh9C;
        ack_en = 1'b0;
        tx_len = 8'h14;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(`UCSMA_ADDR_CSMA_CFG, d0);
        chk8(d0, `UCSMA_RST_CFG);
        rd_reg(`UCSMA_ADDR_CCA_THRES, d0);
        chk8(d0, `UCSMA_RST_THRES);
        rd_reg(`UCSMA_ADDR_MAC_DELAY, d0);
        chk8(d0, `UCSMA_RST_DELAY);
        rd_reg(12'h7FF, d0);
        chk8(d0, 8'h00);
        // readback ignores writes
        rd_reg(`UCSMA_ADDR_RSSI_RB, d0);
        wr_reg(`UCSMA_ADDR_RSSI_RB, ~d0);
        rd_reg(`UCSMA_ADDR_RSSI_RB, d1);
        chk8(d1, d0);
        wr_reg(`UCSMA_ADDR_MAC_DELAY, 8'h02);
        wr_reg(`UCSMA_ADDR_TX_BASE, 8'h10);
        wr_reg(`UCSMA_ADDR_BUF_BASE + 12'h011, 8'h00);
        wr_reg(`UCSMA_ADDR_GAIN_CFG5, 8'h00);
        // clear channel, no ack wanted: one frame then straight to idle
        wr_reg(`UCSMA_ADDR_CSMA_CFG, 8'h42);
        run_proc();
        chkb(n_tx == 1, 1'b1);
        chkb(access_fail, 1'b0);
        chkb(t_tx - t0 >= 2 * US + CCA + TURN - 2, 1'b1);
        chkb(now_c - t_last <= 20 + 6, 1'b1);
        rd_reg(`UCSMA_ADDR_RSSI_RB, d0);
        chk8(d0, 8'h9C);
        // busy channel, cca retries 0 then 5: every check finds it busy, then abort without sending
        level = 8'shCE;
        for (int i = 0; i <= 5; i += 5) begin
            wr_reg(`UCSMA_ADDR_CSMA_CFG, 8'h40 | 8'(i));
            run_proc();
            chkb(n_tx == 0, 1'b1);
            chkb(access_fail, 1'b1);
            chkb(cyc >= (i + 1) * CCA, 1'b1);
        end
        // access check off, host sets one retry: send despite busy air
        wr_reg(`UCSMA_ADDR_CSMA_CFG, 8'h01);
        run_proc();
        chkb(n_tx == 1, 1'b1);
        chkb(t_tx - t0 < CCA, 1'b1);
        // ack wanted by frame bit, then by force bit: one frame retry
        level = 8'sh9C;
        tx_len = 8'h03;
        for (int k = 0; k < 2; k++) begin
            wr_reg(`UCSMA_ADDR_BUF_BASE + 12'h011, k == 0 ? 8'h20 : 8'h00);
            wr_reg(`UCSMA_ADDR_CSMA_CFG, k == 0 ? 8'h4A : 8'hCA);
            ack_en = 1'b0;
            run_proc();
            chkb(n_tx == 2, 1'b1);
            chkb(access_fail, 1'b1);
            chkb(now_c - t_last >= 3 + ACK - 2 && now_c - t_last <= 3 + ACK + 8, 1'b1);
            ack_en = 1'b1;
            run_proc();
            chkb(n_tx == 1, 1'b1);
            chkb(access_fail, 1'b0);
        end
        // readback offset of 3 dB
        wr_reg(`UCSMA_ADDR_BUF_BASE + 12'h011, 8'h00);
        wr_reg(`UCSMA_ADDR_GAIN_CFG5, 8'h0C);
        wr_reg(`UCSMA_ADDR_CSMA_CFG, 8'h42);
        run_proc();
        rd_reg(`UCSMA_ADDR_RSSI_RB, d0);
        chk8(d0, 8'h9F);
        report_and_stop();
    end
endmodule
`default_nettype wire
